// File: core/sto_pkg.sv
// package: constants, codes and carriers for the safe torque off monitor
package sto_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned TRIG_DELAY_MS = 10;
  localparam int unsigned COMMANDED_IND_MS = 100;
  localparam int unsigned DISCREP_IND_MS = 280;
  localparam int unsigned SWITCH_TRAVEL_MS = 200;
  localparam int unsigned DISCREP_CYCLES = CLK_PER_MS * SWITCH_TRAVEL_MS;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned CNT_W = 23;

  // ****************************************
  // fault codes
  // ****************************************
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_COMMANDED = 3'h1;
  localparam logic [2:0] CODE_A_ABNORMAL = 3'h2;
  localparam logic [2:0] CODE_B_ABNORMAL = 3'h3;
  localparam logic [2:0] CODE_BOTH_ABNORMAL = 3'h4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_DRIVE = 1'h0;
  localparam logic RST_RUN = 1'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_NORMAL = 2'h0,
    ST_DISCREP = 2'h1,
    ST_LOCKED = 2'h3,
    ST_COMMANDED = 2'h2
  } sto_state_e;

  typedef struct packed {
    logic a_closed;
    logic b_closed;
  } chan_s;

  typedef struct packed {
    logic start_cmd;
    logic stop_cmd;
    logic reset_key;
  } cmd_s;

endpackage : sto_pkg

// File: core/chan_sync.sv
// module: multi-stage synchronizer for one safety channel
`timescale 1ns/1ps
`default_nettype none
module chan_sync #(
  parameter int unsigned STAGES = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic raw_in,
  output logic sync_out
);

  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;

  // ****************************************
  // shift chain, first stage read only by second
  // ****************************************
  always_comb begin
    nxt_stage = {stage_ff[STAGES-2:0], raw_in};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  assign sync_out = stage_ff[STAGES-1];

endmodule : chan_sync
`default_nettype wire

// File: core/sto_monitor.sv
// module: dual channel safe torque off monitor
// Function
// - both closed: drive permitted, no fault
// - both open: torque off, commanded code
// - first open alone: torque off, first-channel fault
// - second open alone: torque off, second-channel fault
// - distinct code for both channels abnormal
// - drive output off under ten milliseconds
// - channel fault indicated under 280 milliseconds
// - commanded stop indicated under 100 milliseconds
// - any fault ignores run, output disabled
// - reset with channels open keeps output off
// - channels closed: reset clears, start runs again
// - channel faults cleared only by power cycle
// - single channel open: immediate coast, fault
// - channel low means open, high closed
// - torque off overrides every other request
// - commanded fault cleared by reset key, channels closed
// - commanded fault auto-clear by setting
`timescale 1ns/1ps
`default_nettype none
module sto_monitor #(
  parameter int unsigned DISCREP_CYCLES = sto_pkg::DISCREP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic safety_channel_a,
  input wire logic safety_channel_b,
  input wire sto_pkg::cmd_s cmd,
  input wire logic fault_auto_reset_setting,
  output logic drive_enable_ff,
  output logic run_active_ff,
  output logic fault_indication_ff,
  output logic [2:0] fault_code_ff
);

  localparam logic [sto_pkg::CNT_W-1:0] DISCREP_LAST = sto_pkg::CNT_W'(DISCREP_CYCLES - 1);

  // ****************************************
  // channel synchronizers
  // ****************************************
  sto_pkg::chan_s chan;

  chan_sync #(.STAGES(sto_pkg::SYNC_STAGES)) u_sync_a (
    .clk(clk),
    .reset_n(reset_n),
    .raw_in(safety_channel_a),
    .sync_out(chan.a_closed)
  );

  chan_sync #(.STAGES(sto_pkg::SYNC_STAGES)) u_sync_b (
    .clk(clk),
    .reset_n(reset_n),
    .raw_in(safety_channel_b),
    .sync_out(chan.b_closed)
  );

  function automatic logic is_channel_fault(input logic [2:0] code);
    is_channel_fault = (code == sto_pkg::CODE_A_ABNORMAL) || (code == sto_pkg::CODE_B_ABNORMAL)
      || (code == sto_pkg::CODE_BOTH_ABNORMAL);
  endfunction : is_channel_fault

  logic both_closed;
  logic both_open;
  logic a_alone;
  logic b_alone;

  always_comb begin
    both_closed = chan.a_closed && chan.b_closed;
    both_open = !chan.a_closed && !chan.b_closed;
    a_alone = !chan.a_closed && chan.b_closed;
    b_alone = chan.a_closed && !chan.b_closed;
  end

  // ****************************************
  // classification state machine
  // ****************************************
  sto_pkg::sto_state_e state_ff;
  sto_pkg::sto_state_e nxt_state;
  logic [sto_pkg::CNT_W-1:0] cnt_ff;
  logic [sto_pkg::CNT_W-1:0] nxt_cnt;
  logic first_a_ff;
  logic nxt_first_a;
  logic both_seen_ff;
  logic nxt_both_seen;
  logic [2:0] nxt_code;
  logic clear_ok;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_first_a = first_a_ff;
    nxt_both_seen = both_seen_ff;
    nxt_code = fault_code_ff;
    clear_ok = both_closed && (cmd.reset_key || fault_auto_reset_setting);
    case (state_ff)
      sto_pkg::ST_NORMAL: begin
        nxt_cnt = '0;
        nxt_both_seen = 1'h0;
        if (both_open) begin
          nxt_state = sto_pkg::ST_COMMANDED;
          nxt_code = sto_pkg::CODE_COMMANDED;
        end else if (a_alone || b_alone) begin
          nxt_state = sto_pkg::ST_DISCREP;
          nxt_first_a = a_alone;
        end
      end
      sto_pkg::ST_DISCREP: begin
        nxt_cnt = cnt_ff + 1'h1;
        if (both_open) begin
          nxt_state = sto_pkg::ST_COMMANDED;
          nxt_code = sto_pkg::CODE_COMMANDED;
        end else if (both_closed) begin
          nxt_state = sto_pkg::ST_NORMAL;
        end else begin
          if (a_alone != first_a_ff) begin
            nxt_both_seen = 1'h1;
          end
          if (cnt_ff == DISCREP_LAST) begin
            nxt_state = sto_pkg::ST_LOCKED;
            if (nxt_both_seen) begin
              nxt_code = sto_pkg::CODE_BOTH_ABNORMAL;
            end else if (first_a_ff) begin
              nxt_code = sto_pkg::CODE_A_ABNORMAL;
            end else begin
              nxt_code = sto_pkg::CODE_B_ABNORMAL;
            end
          end
        end
      end
      sto_pkg::ST_COMMANDED: begin
        if (clear_ok) begin
          nxt_state = sto_pkg::ST_NORMAL;
          nxt_code = sto_pkg::CODE_NONE;
        end
      end
      sto_pkg::ST_LOCKED: begin
        nxt_state = sto_pkg::ST_LOCKED;
      end
      default: begin
        nxt_state = sto_pkg::ST_LOCKED;
        nxt_code = sto_pkg::CODE_BOTH_ABNORMAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= sto_pkg::ST_NORMAL;
      cnt_ff <= '0;
      first_a_ff <= 1'h0;
      both_seen_ff <= 1'h0;
      fault_code_ff <= sto_pkg::CODE_NONE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      first_a_ff <= nxt_first_a;
      both_seen_ff <= nxt_both_seen;
      fault_code_ff <= nxt_code;
    end
  end

  // ****************************************
  // run latch and drive gate
  // ****************************************
  logic nxt_run;
  logic nxt_drive;
  logic nxt_ind;

  always_comb begin
    nxt_run = run_active_ff;
    if (state_ff != sto_pkg::ST_NORMAL || !both_closed) begin
      nxt_run = 1'h0;
    end else if (cmd.stop_cmd) begin
      nxt_run = 1'h0;
    end else if (cmd.start_cmd) begin
      nxt_run = 1'h1;
    end
    nxt_drive = nxt_run;
    nxt_ind = (nxt_code != sto_pkg::CODE_NONE);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_active_ff <= sto_pkg::RST_RUN;
      drive_enable_ff <= sto_pkg::RST_DRIVE;
      fault_indication_ff <= 1'h0;
    end else begin
      run_active_ff <= nxt_run;
      drive_enable_ff <= nxt_drive;
      fault_indication_ff <= nxt_ind;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_normal_run;
    (state_ff == sto_pkg::ST_NORMAL) && both_closed && cmd.start_cmd && !cmd.stop_cmd
      |=> drive_enable_ff && !fault_indication_ff;
  endproperty
  a_normal_run: assert property (p_normal_run) else $error("run refused with channels closed");

  property p_both_open;
    (state_ff != sto_pkg::ST_LOCKED) && both_open
      |=> !drive_enable_ff && fault_code_ff == sto_pkg::CODE_COMMANDED && fault_indication_ff;
  endproperty
  a_both_open: assert property (p_both_open) else $error("commanded stop not reported");

  property p_a_fault;
    (state_ff == sto_pkg::ST_DISCREP) && a_alone && first_a_ff && !both_seen_ff
      && cnt_ff == DISCREP_LAST |=> fault_code_ff == sto_pkg::CODE_A_ABNORMAL;
  endproperty
  a_a_fault: assert property (p_a_fault) else $error("first channel fault missing");

  property p_b_fault;
    (state_ff == sto_pkg::ST_DISCREP) && b_alone && !first_a_ff && !both_seen_ff
      && cnt_ff == DISCREP_LAST |=> fault_code_ff == sto_pkg::CODE_B_ABNORMAL;
  endproperty
  a_b_fault: assert property (p_b_fault) else $error("second channel fault missing");

  property p_both_fault;
    (state_ff == sto_pkg::ST_DISCREP) && (a_alone || b_alone) && cnt_ff == DISCREP_LAST
      && (both_seen_ff || (a_alone != first_a_ff))
      |=> fault_code_ff == sto_pkg::CODE_BOTH_ABNORMAL;
  endproperty
  a_both_fault: assert property (p_both_fault) else $error("both channel fault missing");

  property p_coast;
    (state_ff == sto_pkg::ST_NORMAL) && (a_alone || b_alone)
      |=> !drive_enable_ff && !run_active_ff && state_ff == sto_pkg::ST_DISCREP;
  endproperty
  a_coast: assert property (p_coast) else $error("single channel open left drive on");

  property p_trigger;
    $fell(safety_channel_a) || $fell(safety_channel_b) |-> ##[1:5] !drive_enable_ff;
  endproperty
  a_trigger: assert property (p_trigger) else $error("drive not switched off in time");

  property p_fault_blocks;
    fault_code_ff != sto_pkg::CODE_NONE |=> !drive_enable_ff && !run_active_ff;
  endproperty
  a_fault_blocks: assert property (p_fault_blocks) else $error("drive on during fault");

  sequence s_commanded_open_reset;
    fault_code_ff == sto_pkg::CODE_COMMANDED && !both_closed && cmd.reset_key;
  endsequence

  property p_reset_open;
    s_commanded_open_reset |=> fault_code_ff == sto_pkg::CODE_COMMANDED ##1 !drive_enable_ff;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("reset cleared with channels open");

  sequence s_commanded_closed_reset;
    state_ff == sto_pkg::ST_COMMANDED && both_closed && cmd.reset_key;
  endsequence

  property p_reset_closed;
    s_commanded_closed_reset |=> fault_code_ff == sto_pkg::CODE_NONE && !fault_indication_ff;
  endproperty
  a_reset_closed: assert property (p_reset_closed) else $error("commanded fault not cleared");

  property p_locked;
    is_channel_fault(fault_code_ff) |=> $stable(fault_code_ff) && fault_indication_ff;
  endproperty
  a_locked: assert property (p_locked) else $error("channel fault released");

endmodule : sto_monitor
`default_nettype wire

// File: bench/safety_switch_model.sv
// model: external safety switch driving both channel inputs
`timescale 1ns/1ps
`default_nettype none
module safety_switch_model #(
  parameter int unsigned TRAVEL = 2
) (
  input wire logic clk,
  input wire logic want_a,
  input wire logic want_b,
  output logic ch_a,
  output logic ch_b
);
  logic [TRAVEL-1:0] pipe_a = '1;
  logic [TRAVEL-1:0] pipe_b = '1;
  // contacts settle a few cycles after the request, well inside the travel limit
  always @(posedge clk) begin
    pipe_a <= {pipe_a[TRAVEL-2:0], want_a};
    pipe_b <= {pipe_b[TRAVEL-2:0], want_b};
  end
  // closed contact drives high, open contact leaves the line low
  assign ch_a = pipe_a[TRAVEL-1];
  assign ch_b = pipe_b[TRAVEL-1];
endmodule : safety_switch_model
`default_nettype wire

// File: bench/sto_monitor_tb.sv
// bench: self-checking testbench for the safe torque off monitor
`timescale 1ns/1ps
`default_nettype none
module sto_monitor_tb;
  localparam int unsigned DCYC = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic want_a = 1'b1;
  logic want_b = 1'b1;
  logic auto_set = 1'b0;
  sto_pkg::cmd_s cmd = '0;
  logic ch_a;
  logic ch_b;
  logic drive;
  logic run;
  logic ind;
  logic [2:0] code;
  int mismatches = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;

  safety_switch_model u_sw (.clk(clk), .want_a(want_a), .want_b(want_b), .ch_a(ch_a), .ch_b(ch_b));
  sto_monitor #(.DISCREP_CYCLES(DCYC)) u_dut (.clk(clk), .reset_n(reset_n),
    .safety_channel_a(ch_a), .safety_channel_b(ch_b), .cmd(cmd),
    .fault_auto_reset_setting(auto_set), .drive_enable_ff(drive),
    .run_active_ff(run), .fault_indication_ff(ind), .fault_code_ff(code));

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task wait_code(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && code !== exp; i++) step(1);
    chk("fault_code", exp, code);
    chk("fault_indication", {2'h0, exp != 3'h0}, {2'h0, ind});
  endtask : wait_code

  task wait_off(input int lim);
    for (int i = 0; i < lim && drive !== 1'b0; i++) step(1);
    chk("drive_enable", 3'h0, {2'h0, drive});
    chk("run_active", 3'h0, {2'h0, run});
  endtask : wait_off

  task key;
    cmd.reset_key = 1'b1;
    step(1);
    cmd.reset_key = 1'b0;
    step(1);
  endtask : key

  task start(input logic exp);
    cmd.start_cmd = 1'b1;
    step(1);
    cmd.start_cmd = 1'b0;
    chk("drive_enable", {2'h0, exp}, {2'h0, drive});
    chk("run_active", {2'h0, exp}, {2'h0, run});
    step(1);
  endtask : start

  task power_up;
    want_a = 1'b1;
    want_b = 1'b1;
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step(10);
    key();
    wait_code(3'h0, 10);
  endtask : power_up

  task t_start_stop;
    cmd.start_cmd = 1'b1;
    cmd.stop_cmd = 1'b1;
    step(2);
    cmd.start_cmd = 1'b0;
    cmd.stop_cmd = 1'b0;
    chk("drive_enable", 3'h0, {2'h0, drive});
    start(1'b1);
    cmd.stop_cmd = 1'b1;
    step(2);
    cmd.stop_cmd = 1'b0;
    chk("drive_enable", 3'h0, {2'h0, drive});
  endtask : t_start_stop

  task t_commanded;
    start(1'b1);
    want_a = 1'b0;
    want_b = 1'b0;
    wait_off(12);
    wait_code(3'h1, 12);
    start(1'b0);
    key();
    wait_code(3'h1, 1);
    start(1'b0);
    want_a = 1'b1;
    want_b = 1'b1;
    step(10);
    wait_code(3'h1, 1);
    key();
    wait_code(3'h0, 4);
    start(1'b1);
  endtask : t_commanded

  task t_auto;
    auto_set = 1'b1;
    want_a = 1'b0;
    want_b = 1'b0;
    wait_code(3'h1, 12);
    want_a = 1'b1;
    want_b = 1'b1;
    wait_code(3'h0, 14);
    auto_set = 1'b0;
    start(1'b1);
  endtask : t_auto

  task t_single(input logic on_a);
    start(1'b1);
    if (on_a) want_a = 1'b0;
    else want_b = 1'b0;
    wait_off(12);
    wait_code(on_a ? 3'h2 : 3'h3, DCYC + 12);
    want_a = 1'b1;
    want_b = 1'b1;
    step(10);
    key();
    wait_code(on_a ? 3'h2 : 3'h3, 1);
    start(1'b0);
    power_up();
    start(1'b1);
  endtask : t_single

  task t_both_abnormal;
    want_a = 1'b0;
    step(6);
    want_a = 1'b1;
    want_b = 1'b0;
    wait_code(3'h4, DCYC + 12);
    want_b = 1'b1;
    step(10);
    key();
    wait_code(3'h4, 1);
    start(1'b0);
    power_up();
  endtask : t_both_abnormal

  task t_bounce;
    want_b = 1'b0;
    step(5);
    want_b = 1'b1;
    step(DCYC + 10);
    wait_code(3'h0, 1);
    start(1'b1);
  endtask : t_bounce

  task t_late_pair;
    want_a = 1'b0;
    step(3);
    want_b = 1'b0;
    wait_off(12);
    wait_code(3'h1, 16);
    want_a = 1'b1;
    want_b = 1'b1;
    step(10);
    key();
    wait_code(3'h0, 1);
    start(1'b1);
  endtask : t_late_pair

  task results;
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  initial begin
    power_up();
    t_start_stop();
    t_commanded();
    t_auto();
    t_single(1'b1);
    t_single(1'b0);
    t_both_abnormal();
    t_bounce();
    t_late_pair();
    results();
  end

  initial begin
    #500000;
    mismatches++;
    results();
  end
endmodule : sto_monitor_tb
`default_nettype wire
